// ===== dlp_pkg.sv
// shared constants for the phy reset and management port
package dlp_pkg;
  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned ADDR_W       = 9;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned CAL_CYC      = 16;
  // word addresses of the management register space
  localparam logic [8:0]  A_ID         = 9'h000;
  localparam logic [8:0]  A_CAL_PD     = 9'h021;
  localparam logic [8:0]  A_PLL_LOCK   = 9'h022;
  localparam logic [8:0]  A_CAL_STAT   = 9'h023;
  localparam logic [8:0]  A_RST_STAT   = 9'h024;
  localparam logic [8:0]  A_RECAL      = 9'h025;
  localparam logic [8:0]  A_LOOPBACK   = 9'h061;
  localparam logic [8:0]  A_LTD        = 9'h064;
  localparam logic [8:0]  A_LTR        = 9'h065;
  localparam logic [8:0]  A_PLL_CFG    = 9'h070;
  localparam logic [31:0] PLL_CFG_RST  = 32'h0000_0000;
  // host command register addresses
  localparam logic [3:0]  H_RST_CTRL   = 4'h0;
  localparam logic [3:0]  H_STATUS     = 4'h1;
  localparam logic [3:0]  H_MADDR      = 4'h2;
  localparam logic [3:0]  H_MWDATA     = 4'h3;
  localparam logic [3:0]  H_MCMD       = 4'h4;
  localparam logic [3:0]  H_MRDATA     = 4'h5;
  // host reset control field positions
  localparam int unsigned F_PLLPD      = 0;
  localparam int unsigned F_TXA        = 1;
  localparam int unsigned F_TXD        = 2;
  localparam int unsigned F_RXA        = 3;
  localparam int unsigned F_RXD        = 4;
  localparam int unsigned F_AUTO       = 5;
endpackage : dlp_pkg

// ===== dlp_if.sv
// reset, calibration and management signals between sequencer and phy
`timescale 1ns/1ps
interface dlp_if #(
  parameter int N = 4
);
  logic [N-1:0]  pll_pd;
  logic [N-1:0]  tx_d_rst;
  logic [N-1:0]  tx_a_rst;
  logic [N-1:0]  rx_d_rst;
  logic [N-1:0]  rx_a_rst;
  logic [N-1:0]  tx_cal_busy;
  logic [N-1:0]  rx_cal_busy;
  logic [8:0]    mgmt_address;
  logic [31:0]   mgmt_writedata;
  logic [31:0]   mgmt_readdata;
  logic          mgmt_write;
  logic          mgmt_read;
  logic          mgmt_waitrequest;
  modport phy (
    input  pll_pd, tx_d_rst, tx_a_rst, rx_d_rst, rx_a_rst,
    output tx_cal_busy, rx_cal_busy,
    input  mgmt_address, mgmt_writedata, mgmt_write, mgmt_read,
    output mgmt_readdata, mgmt_waitrequest
  );
  modport seq (
    output pll_pd, tx_d_rst, tx_a_rst, rx_d_rst, rx_a_rst,
    input  tx_cal_busy, rx_cal_busy,
    output mgmt_address, mgmt_writedata, mgmt_write, mgmt_read,
    input  mgmt_readdata, mgmt_waitrequest
  );
endinterface : dlp_if

// ===== dlp_phy.sv
// phy end: per-channel resets, calibration status, management slave
// Contract
// (R1) pins exist only without embedded reset controller
// (R2) pll powerdown holds tx pll reset
// (R3) tx digital reset holds tx coding
// (R4) tx analog reset holds tx attachment
// (R5) tx cal busy during initial tx calibration
// (R6) cal busy high while reconfig controller resets
// (R7) manual recalibration leaves cal busy low
// (R8) sequencer holds reset until cal busy drops
// (R9) rx digital reset holds rx coding
// (R10) rx analog reset holds rx cdr
// (R11) rx cal busy during initial rx calibration
// (R12) management reset active high, level, global
// (R13) 9-bit word address, 32-bit data
// (R14) waitrequest while request cannot be answered
// (R15) master holds request during waitrequest
// (R16) master avoids reserved addresses
// (R17) one shared register address space
// (R18) registers steer coding, attachment, pll, loopback
// (R19) shared clock kept within 100-150 mhz; the testbench runs core_clk at 40 mhz
// (R20) one bit per channel, bit n only
// (R21) read data valid when waitrequest low
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module dlp_phy #(
  parameter int          N       = dlp_pkg::NUM_CH,
  parameter int          CAL_CYC = dlp_pkg::CAL_CYC,
  parameter logic [31:0] ID_VAL  = 32'h0000_5a5a  // arbitrary value
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // link to sequencer
  dlp_if.phy                lnk,
  // reconfiguration controller reset and per-channel status
  input  wire logic         reconfig_rst,
  output logic [N-1:0]      tx_pll_in_rst,
  output logic [N-1:0]      tx_pcs_in_rst,
  output logic [N-1:0]      tx_pma_in_rst,
  output logic [N-1:0]      rx_pcs_in_rst,
  output logic [N-1:0]      rx_cdr_in_rst,
  output logic [N-1:0]      serial_loopback,
  output logic [N-1:0]      cdr_lock_data,
  output logic [N-1:0]      cdr_lock_ref,
  output logic [31:0]       pll_cfg
);
  localparam int CW = $clog2(CAL_CYC + 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_RESP = 3'b100
  } dlp_mst_t;

  typedef struct packed {
    logic [1:0]     sync_rr;
    logic [N-1:0]   tx_cal;
    logic [N-1:0]   rx_cal;
    logic [N-1:0]   init_done;
    logic [N-1:0]   recal;
    logic [N-1:0][CW-1:0] cnt;
    logic [N-1:0]   cal_pd;
    logic [N-1:0]   loopback;
    logic [N-1:0]   ltd;
    logic [N-1:0]   ltr;
    logic [31:0]    pll_cfg;
    logic [31:0]    rdata;
    dlp_mst_t       mst;
  } dlp_phy_st_t;

  dlp_phy_st_t s_r;
  dlp_phy_st_t s_nxt;

  // one shared decode of the word address space
  function automatic logic [31:0] rd_mux(input logic [8:0] a, input dlp_phy_st_t s,
                                         input logic [N-1:0] lk);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)  // see (R17)
      dlp_pkg::A_ID:       v = ID_VAL;
      dlp_pkg::A_CAL_PD:   v[N-1:0] = s.cal_pd;
      dlp_pkg::A_PLL_LOCK: v[N-1:0] = lk;
      dlp_pkg::A_CAL_STAT: v = {16'h0000, 8'(s.rx_cal), 8'(s.tx_cal)};
      dlp_pkg::A_RST_STAT: v = {24'h0000_00, 8'(s.init_done)};
      dlp_pkg::A_LOOPBACK: v[N-1:0] = s.loopback;
      dlp_pkg::A_LTD:      v[N-1:0] = s.ltd;
      dlp_pkg::A_LTR:      v[N-1:0] = s.ltr;
      dlp_pkg::A_PLL_CFG:  v = s.pll_cfg;
      // unmapped words read as zero and touch nothing
      default:             v = 32'h0000_0000;
    endcase
    return v;
  endfunction : rd_mux

  // reset paths are combinational: each hold lasts as long as its input, tx_pma_in_rst also while cal_pd is set
  always_comb
  begin
    tx_pll_in_rst = lnk.pll_pd;  // see (R2) (R20)
    tx_pcs_in_rst = lnk.tx_d_rst;  // see (R3)
    // a powered-down calibration block also parks the tx attachment
    tx_pma_in_rst = lnk.tx_a_rst | s_r.cal_pd;  // see (R4)
    rx_pcs_in_rst = lnk.rx_d_rst;  // see (R9)
    rx_cdr_in_rst = lnk.rx_a_rst;  // see (R10)
  end

  always_comb
  begin
    s_nxt = s_r;
    // reconfig reset comes from another block: two flops before use
    s_nxt.sync_rr = {s_r.sync_rr[0], reconfig_rst};
    for (int i = 0; i < N; i++)
    begin
      // calibration runs once per channel, or again after reconfig reset or a manual recal request
      if (s_r.sync_rr[1])
      begin
        s_nxt.init_done[i] = 1'b0;
        s_nxt.cnt[i] = '0;
        s_nxt.tx_cal[i] = 1'b1;  // see (R6)
        s_nxt.rx_cal[i] = 1'b1;  // see (R6)
      end
      else if (!s_r.init_done[i])
      begin
        s_nxt.tx_cal[i] = 1'b1;  // see (R5)
        s_nxt.rx_cal[i] = 1'b1;  // see (R11)
        // busy stands CAL_CYC cycles: cnt runs 1..CAL_CYC while it is high
        if (s_r.cnt[i] == CW'(CAL_CYC))
        begin
          s_nxt.init_done[i] = 1'b1;
          s_nxt.tx_cal[i] = 1'b0;
          s_nxt.rx_cal[i] = 1'b0;
          s_nxt.cnt[i] = '0;
        end
        else
          s_nxt.cnt[i] = s_r.cnt[i] + CW'(1);
      end
      else if (s_r.recal[i])
      begin
        // manual recalibration: busy stays low
        s_nxt.tx_cal[i] = 1'b0;  // see (R7)
        s_nxt.rx_cal[i] = 1'b0;  // see (R7)
        // as long as an initial run, but busy stays hidden
        if (s_r.cnt[i] == CW'(CAL_CYC))
        begin
          s_nxt.recal[i] = 1'b0;
          s_nxt.cnt[i] = '0;
        end
        else
          s_nxt.cnt[i] = s_r.cnt[i] + CW'(1);
      end
    end
    // two wait cycles per access so readdata stands with waitrequest low
    case (s_r.mst)
      // a strobe still high after the response starts the next access
      ST_IDLE:
        if (lnk.mgmt_read || lnk.mgmt_write)
          s_nxt.mst = ST_BUSY;  // see (R14)
      ST_BUSY:
      begin
        s_nxt.mst = ST_RESP;
        if (lnk.mgmt_read)
          s_nxt.rdata = rd_mux(lnk.mgmt_address, s_r, ~lnk.pll_pd);  // see (R13)
        if (lnk.mgmt_write)
        begin
          // unmapped writes are dropped, avoiding side effects
          case (lnk.mgmt_address)  // see (R18)
            dlp_pkg::A_CAL_PD:   s_nxt.cal_pd = lnk.mgmt_writedata[N-1:0];
            dlp_pkg::A_RECAL:
              // a request landing as a recal run ends wins; other ends are kept; one landing before init_done is dropped
              s_nxt.recal = s_nxt.recal | (lnk.mgmt_writedata[N-1:0] & s_r.init_done);
            dlp_pkg::A_LOOPBACK: s_nxt.loopback = lnk.mgmt_writedata[N-1:0];
            dlp_pkg::A_LTD:      s_nxt.ltd = lnk.mgmt_writedata[N-1:0];
            dlp_pkg::A_LTR:      s_nxt.ltr = lnk.mgmt_writedata[N-1:0];
            dlp_pkg::A_PLL_CFG:  s_nxt.pll_cfg = lnk.mgmt_writedata;
            default:             s_nxt.pll_cfg = s_r.pll_cfg;
          endcase
        end
      end
      ST_RESP:
        s_nxt.mst = ST_IDLE;
      default:
        s_nxt.mst = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    // level reset: state stays cleared for as long as rst is high
    if (rst)  // see (R12)
    begin
      s_r         <= '0;
      s_r.pll_cfg <= dlp_pkg::PLL_CFG_RST;
      s_r.mst     <= ST_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // pins only present in this manual-reset configuration
  assign lnk.tx_cal_busy      = s_r.tx_cal;  // see (R1)
  assign lnk.rx_cal_busy      = s_r.rx_cal;
  // with a strobe high, low only in the response cycle, so a held strobe is answered every third cycle
  assign lnk.mgmt_waitrequest = (lnk.mgmt_read | lnk.mgmt_write) & (s_r.mst != ST_RESP);
  assign lnk.mgmt_readdata    = s_r.rdata;  // see (R21)
  assign serial_loopback      = s_r.loopback;
  assign cdr_lock_data        = s_r.ltd;
  assign cdr_lock_ref         = s_r.ltr;
  assign pll_cfg              = s_r.pll_cfg;
endmodule : dlp_phy

// ===== dlp_seq.sv
// sequencer end: reset drive and management master under software control
`timescale 1ns/1ps
module dlp_seq #(
  parameter int N = dlp_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // software port
  input  wire logic [3:0]   sw_addr,
  input  wire logic [31:0]  sw_wdata,
  input  wire logic         sw_wr,
  input  wire logic         sw_rd,
  output logic [31:0]       sw_rdata,
  // link to phy
  dlp_if.seq                lnk
);
  typedef enum logic [1:0] {
    SM_IDLE = 2'b01,
    SM_BUSY = 2'b10
  } dlp_sm_t;

  typedef struct packed {
    logic [5:0]   ctrl;
    logic [8:0]   maddr;
    logic [31:0]  mwdata;
    logic [31:0]  mrdata;
    logic         mwr;
    logic         mrd;
    logic         done;
    logic [31:0]  rdata;
    dlp_sm_t      sm;
  } dlp_seq_st_t;

  dlp_seq_st_t s_r;
  dlp_seq_st_t s_nxt;
  logic [N-1:0] hold_tx;
  logic [N-1:0] hold_rx;

  // keep each channel reset while its calibration runs; busy is a flop on
  // this same clock, so it is used directly and the hold starts with it
  assign hold_tx = lnk.tx_cal_busy;  // see (R8)
  assign hold_rx = lnk.rx_cal_busy;  // see (R8)

  always_comb
  begin
    s_nxt = s_r;
    case (s_r.sm)
      SM_IDLE: s_nxt.sm = SM_IDLE;
      SM_BUSY:
        // request held steady until waitrequest drops
        if (!lnk.mgmt_waitrequest)  // see (R15)
        begin
          if (s_r.mrd)
            s_nxt.mrdata = lnk.mgmt_readdata;  // see (R21)
          s_nxt.mwr = 1'b0;
          s_nxt.mrd = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.sm = SM_IDLE;
        end
      default: s_nxt.sm = SM_IDLE;
    endcase
    // software decode last, so a new command is not undone by the idle step
    if (sw_wr)
      case (sw_addr)
        dlp_pkg::H_RST_CTRL: s_nxt.ctrl = sw_wdata[5:0];
        // address and data stay frozen while an access waits
        dlp_pkg::H_MADDR:
          if (s_r.sm == SM_IDLE)
            s_nxt.maddr = sw_wdata[8:0];  // see (R15)
        dlp_pkg::H_MWDATA:
          if (s_r.sm == SM_IDLE)
            s_nxt.mwdata = sw_wdata;  // see (R15)
        dlp_pkg::H_MCMD:
          if (s_r.sm == SM_IDLE)
          begin
            s_nxt.mwr = sw_wdata[0];
            s_nxt.mrd = ~sw_wdata[0];
            s_nxt.done = 1'b0;
            s_nxt.sm = SM_BUSY;
          end
        default: s_nxt.ctrl = s_r.ctrl;
      endcase
    s_nxt.rdata = 32'h0000_0000;
    if (sw_rd)
      case (sw_addr)
        dlp_pkg::H_RST_CTRL: s_nxt.rdata = {26'h0, s_r.ctrl};
        dlp_pkg::H_STATUS:
          s_nxt.rdata = {14'h0, s_r.done, s_r.sm == SM_BUSY, 8'(hold_rx), 8'(hold_tx)};
        dlp_pkg::H_MADDR:    s_nxt.rdata = {23'h0, s_r.maddr};
        dlp_pkg::H_MWDATA:   s_nxt.rdata = s_r.mwdata;
        dlp_pkg::H_MRDATA:   s_nxt.rdata = s_r.mrdata;
        default:             s_nxt.rdata = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_r      <= '0;
      s_r.ctrl <= 6'h1f;
      s_r.sm   <= SM_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  // auto bit adds calibration hold to the software-set tx and rx resets, not to pll powerdown
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      lnk.pll_pd[i]   = s_r.ctrl[dlp_pkg::F_PLLPD];
      lnk.tx_a_rst[i] = s_r.ctrl[dlp_pkg::F_TXA] | (s_r.ctrl[dlp_pkg::F_AUTO] & hold_tx[i]);
      lnk.tx_d_rst[i] = s_r.ctrl[dlp_pkg::F_TXD] | (s_r.ctrl[dlp_pkg::F_AUTO] & hold_tx[i]);
      lnk.rx_a_rst[i] = s_r.ctrl[dlp_pkg::F_RXA] | (s_r.ctrl[dlp_pkg::F_AUTO] & hold_rx[i]);
      lnk.rx_d_rst[i] = s_r.ctrl[dlp_pkg::F_RXD] | (s_r.ctrl[dlp_pkg::F_AUTO] & hold_rx[i]);
    end
  end

  assign lnk.mgmt_address   = s_r.maddr;
  assign lnk.mgmt_writedata = s_r.mwdata;
  assign lnk.mgmt_write     = s_r.mwr;
  assign lnk.mgmt_read      = s_r.mrd;
  assign sw_rdata           = s_r.rdata;
endmodule : dlp_seq

// ===== dlp_props.sv
// assertions on the link between sequencer and phy
`timescale 1ns/1ps
module dlp_props #(
  parameter int N = 4
) (
  // clock and reset
  input wire logic         core_clk,
  input wire logic         rst,
  // link signals
  input wire logic [N-1:0] tx_cal_busy,
  input wire logic [N-1:0] rx_cal_busy,
  input wire logic [8:0]   mgmt_address,
  input wire logic [31:0]  mgmt_writedata,
  input wire logic [31:0]  mgmt_readdata,
  input wire logic         mgmt_write,
  input wire logic         mgmt_read,
  input wire logic         mgmt_waitrequest
);
  // generous: covers a reconfig reset held for a few cycles
  localparam int CAL_MAX = 40;
  logic req;
  assign req = mgmt_read | mgmt_write;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_reset_clears: assert property (disable iff (1'b0) rst |=>
    tx_cal_busy == '0 && rx_cal_busy == '0 && !req && mgmt_readdata == '0)
    else $error("state not cleared by reset");
  a_wait_idle: assert property (!req |-> !mgmt_waitrequest)
    else $error("waitrequest without request");
  a_wait_bound: assert property (req |-> ##[0:2] !mgmt_waitrequest)
    else $error("request not answered in time");
  a_answer_cycle: assert property (req && !$past(req) |->
    mgmt_waitrequest ##1 mgmt_waitrequest ##1 !mgmt_waitrequest)
    else $error("answer not in third cycle");
  a_master_holds: assert property (mgmt_waitrequest |=> $stable(mgmt_address) &&
    $stable(mgmt_writedata) && $stable(mgmt_read) && $stable(mgmt_write))
    else $error("request changed while waiting");
  a_strobes_apart: assert property (!(mgmt_read && mgmt_write))
    else $error("read and write together");
  a_cal_starts: assert property ($fell(rst) |-> ##[0:3]
    (tx_cal_busy == {N{1'b1}} && rx_cal_busy == {N{1'b1}}))
    else $error("initial calibration not flagged");
  a_cal_ends: assert property ((tx_cal_busy | rx_cal_busy) != '0 |->
    ##[1:CAL_MAX] (tx_cal_busy | rx_cal_busy) == '0)
    else $error("calibration busy stuck");
  c_read: cover property (mgmt_read && !mgmt_waitrequest);
  c_write: cover property (mgmt_write && !mgmt_waitrequest);
  c_cal: cover property ($rose(tx_cal_busy[0]));
endmodule : dlp_props

// ===== testbench.sv
// self-checking bench for the sequencer and phy pair
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module testbench;
  localparam int          N   = 4;
  localparam logic [31:0] IDV = 32'h0000_0c3e;  // arbitrary value
  logic              core_clk, rst, reconfig_rst, sw_wr, sw_rd;
  logic [3:0]        sw_addr;
  logic [31:0]       sw_wdata, sw_rdata, pll_cfg, rd;
  logic [N-1:0]      pll_r, pcs_t, pma_t, pcs_r, cdr_r, lpbk, ltd, ltr;
  logic [N-1:0]      seen;
  int                num_errors = 0;
  int                num_checks = 0;
  int                cyc = 0;
  logic [8:0]        ra [5] = '{dlp_pkg::A_CAL_PD, dlp_pkg::A_LOOPBACK, dlp_pkg::A_LTD,
                                dlp_pkg::A_LTR, dlp_pkg::A_PLL_CFG};
  logic [31:0]       rv [5] = '{32'h2, 32'h5, 32'h3, 32'hc, 32'hdead_beef};
  dlp_if #(.N(N)) lnk ();
  dlp_seq #(.N(N)) i_dlp_seq (.core_clk(core_clk), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .lnk(lnk.seq));
  dlp_phy #(.N(N), .CAL_CYC(4), .ID_VAL(IDV)) i_dlp_phy (.core_clk(core_clk), .rst(rst),
    .lnk(lnk.phy), .reconfig_rst(reconfig_rst), .tx_pll_in_rst(pll_r), .tx_pcs_in_rst(pcs_t),
    .tx_pma_in_rst(pma_t), .rx_pcs_in_rst(pcs_r), .rx_cdr_in_rst(cdr_r),
    .serial_loopback(lpbk), .cdr_lock_data(ltd), .cdr_lock_ref(ltr), .pll_cfg(pll_cfg));
  dlp_props #(.N(N)) i_props (.core_clk(core_clk), .rst(rst), .tx_cal_busy(lnk.tx_cal_busy),
    .rx_cal_busy(lnk.rx_cal_busy), .mgmt_address(lnk.mgmt_address),
    .mgmt_writedata(lnk.mgmt_writedata), .mgmt_readdata(lnk.mgmt_readdata),
    .mgmt_write(lnk.mgmt_write), .mgmt_read(lnk.mgmt_read),
    .mgmt_waitrequest(lnk.mgmt_waitrequest));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;  // not shared with reconfiguration
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // one-cycle strobes with a gap, so no signal is set twice in one step
  task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge core_clk);
    sw_wr    <= 1'b0;
    #1;
  endtask : sw_write
  task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge core_clk);
    sw_rd   <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read
  task automatic mg(input logic wr, input logic [8:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    k = 0;
    sw_write(dlp_pkg::H_MADDR, {23'h0, a});
    sw_write(dlp_pkg::H_MWDATA, d);
    sw_write(dlp_pkg::H_MCMD, {31'h0, wr});
    do
    begin
      sw_read(dlp_pkg::H_STATUS, q);
      k++;
    end
    while (q[17] !== 1'b1 && k < 50);
    `CHK(q[17], 1'b1)
    if (!wr)
      sw_read(dlp_pkg::H_MRDATA, q);
  endtask : mg
  initial
  begin
    rst = 1'b1;
    reconfig_rst = 1'b0;
    sw_addr = '0;
    sw_wdata = '0;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    #1 `CHK({pcs_r, cdr_r, pcs_t, pma_t, pll_r}, 20'hf_ffff)
    sw_read(dlp_pkg::H_RST_CTRL, rd);
    `CHK(rd, 32'h0000_001f)
    `CHK(pll_cfg, dlp_pkg::PLL_CFG_RST)
    for (int f = 0; f < 5; f++)
    begin
      sw_write(dlp_pkg::H_RST_CTRL, 32'h1 << f);
      `CHK({pcs_r, cdr_r, pcs_t, pma_t, pll_r}, 20'hf << (4 * f))
    end
    sw_write(dlp_pkg::H_RST_CTRL, 32'h0);
    mg(1'b0, dlp_pkg::A_PLL_LOCK, 32'h0, rd);
    `CHK(rd, 32'hf)
    for (int i = 0; i < 5; i++)
    begin
      mg(1'b1, ra[i], rv[i], rd);
      mg(1'b0, ra[i], 32'h0, rd);
      `CHK(rd, rv[i])
    end
    `CHK({pma_t, lpbk, ltd, ltr}, 16'h253c)
    `CHK(pll_cfg, 32'hdead_beef)
    mg(1'b0, dlp_pkg::A_ID, 32'h0, rd);
    `CHK(rd, IDV)
    mg(1'b0, dlp_pkg::A_RST_STAT, 32'h0, rd);
    `CHK(rd, 32'h0000_000f)
    // software never writes unmapped words, it only reads them
    mg(1'b0, 9'h1ff, 32'h0, rd);
    `CHK(rd, 32'h0)
    mg(1'b0, 9'h100, 32'h0, rd);
    `CHK(rd, 32'h0)
    sw_read(4'hf, rd);
    `CHK(rd, 32'h0)
    // manual recalibration must stay invisible on the busy flags
    mg(1'b1, dlp_pkg::A_CAL_PD, 32'h0, rd);
    mg(1'b1, dlp_pkg::A_RECAL, 32'hf, rd);
    seen = '0;
    repeat (20)
    begin
      @(posedge core_clk);
      #1 seen |= lnk.tx_cal_busy | lnk.rx_cal_busy;
    end
    `CHK(seen, 4'h0)
    sw_write(dlp_pkg::H_RST_CTRL, 32'h20);
    @(posedge core_clk) reconfig_rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    #1 `CHK({lnk.tx_cal_busy, lnk.rx_cal_busy}, 8'hff)
    `CHK({lnk.tx_a_rst, lnk.tx_d_rst, lnk.rx_a_rst, lnk.rx_d_rst}, 16'hffff)
    mg(1'b0, dlp_pkg::A_CAL_STAT, 32'h0, rd);
    `CHK(rd, 32'h0000_0f0f)
    @(posedge core_clk) reconfig_rst <= 1'b0;
    for (int k = 0; k < 40 && (lnk.tx_cal_busy | lnk.rx_cal_busy) !== '0; k++)
    begin
      @(posedge core_clk);
      #1;
    end
    repeat (4) @(posedge core_clk);
    #1 `CHK({lnk.tx_a_rst, lnk.tx_d_rst, lnk.rx_a_rst, lnk.rx_d_rst}, 16'h0)
    // second reset in mid-run must bring loopback, pll_cfg and the reset control back
    @(posedge core_clk) rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1 `CHK({lpbk, pll_cfg}, {4'h0, dlp_pkg::PLL_CFG_RST})
    sw_read(dlp_pkg::H_RST_CTRL, rd);
    `CHK(rd, 32'h0000_001f)
    conclude();
  end
endmodule : testbench
